// ### rtl/dmc_cache.v
`timescale 1ns/1ps
`include "dmc_cache_defines.vh"

// address split inside the cacheable window, low to high:
//   [1:0]                      byte in word, ignored by the lookup
//   [1+LINE_LOG2:2]            word in line
//   [CACHE_BITS-1:2+LINE_LOG2] line index
//   [RANGE_BITS-1:CACHE_BITS]  tag
// bits above the window are not stored; the range compare stands in for them,
// so the window must be aligned to its own size or two addresses share a tag
// one controller per cache; the two instances share no state, so an instruction
// fill and a data fill may run on their links in the same cycles
// only one access is outstanding per cache, so stores and loads stay in
// program order without any extra ordering logic
// ce low freezes a controller mid-fill; the link partner must then hold
// its response, since a word offered while frozen is lost
// the storage is plain flip-flops, which keeps the lookup in one cycle
// at the cost of area for the larger configurations

module dmc_cache_core #(
    parameter [31:0] RANGE_LOW  = 32'h0000_0000,
    parameter [31:0] RANGE_HIGH = 32'h0000_0FFF,
    parameter        RANGE_BITS = 12,
    parameter        CACHE_BITS = 8,
    parameter        LINE_LOG2  = 2,
    parameter        ALLOW_INV  = 1
) (
    // clock, reset, freeze
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        ce,
    // enable bit from the machine status register
    input  wire        cache_enable,
    // processor side
    input  wire        cpu_valid,
    input  wire [31:0] cpu_addr,
    input  wire        cpu_write,
    input  wire [3:0]  cpu_be,
    input  wire [31:0] cpu_wdata,
    output wire        cpu_ready,
    output wire        cpu_bypass,
    output reg         cpu_ack_q,
    output reg  [31:0] cpu_rdata_q,
    // line invalidate operation
    input  wire        inv_valid,
    input  wire [31:0] inv_addr,
    output wire        inv_ready,
    // line-fill link
    output wire        link_req_valid,
    output wire        link_req_write,
    output reg  [31:0] link_req_addr_q,
    output reg  [3:0]  link_req_be_q,
    output reg  [31:0] link_req_wdata_q,
    input  wire        link_req_ready,
    input  wire        link_rsp_valid,
    input  wire [31:0] link_rsp_data
);
    localparam TW = RANGE_BITS - CACHE_BITS;
    // the index width sets the capacity: 6 index bits is 64 bytes, 16 is 64 kB
    localparam WB = CACHE_BITS - 2;
    localparam LB = CACHE_BITS - 2 - LINE_LOG2;
    localparam NW = 1 << WB;
    localparam NL = 1 << LB;
    localparam LW = 1 << LINE_LOG2;

    reg [1:0]          state_q;
    reg [31:0]         data_mem [0:NW-1];
    reg [TW-1:0]       tag_mem  [0:NL-1];
    reg [NW-1:0]       wvalid_q;
    reg [NL-1:0]       lvalid_q;
    reg [31:0]         op_addr_q;
    reg [LINE_LOG2-1:0] cnt_q;

    wire          in_range  = (cpu_addr >= RANGE_LOW) && (cpu_addr <= RANGE_HIGH);
    wire          cacheable = cache_enable && in_range;
    wire [WB-1:0] widx      = cpu_addr[CACHE_BITS-1:2];
    wire [LB-1:0] lidx      = cpu_addr[CACHE_BITS-1:2+LINE_LOG2];
    wire [TW-1:0] atag      = cpu_addr[RANGE_BITS-1:CACHE_BITS];
    wire          hit       = lvalid_q[lidx] && wvalid_q[widx]
                              && (tag_mem[lidx] == atag);
    // tag and valid bits are read in the address cycle, so a hit answers next cycle
    wire          take      = ce && cpu_valid && cpu_ready && cacheable;

    wire [LB-1:0]        fl_idx  = op_addr_q[CACHE_BITS-1:2+LINE_LOG2];
    wire [TW-1:0]        fl_tag  = op_addr_q[RANGE_BITS-1:CACHE_BITS];
    wire [LINE_LOG2-1:0] fl_word = op_addr_q[2+LINE_LOG2-1:2];
    wire                 fl_last = (cnt_q == {LINE_LOG2{1'b1}});
    wire [LB-1:0]        inv_idx = inv_addr[CACHE_BITS-1:2+LINE_LOG2];

    wire [31:0] old_word = data_mem[widx];
    wire [31:0] merged   = {cpu_be[3] ? cpu_wdata[31:24] : old_word[31:24],
                            cpu_be[2] ? cpu_wdata[23:16] : old_word[23:16],
                            cpu_be[1] ? cpu_wdata[15:8]  : old_word[15:8],
                            cpu_be[0] ? cpu_wdata[7:0]   : old_word[7:0]};

    assign cpu_ready      = (state_q == `DMC_ST_IDLE);
    assign cpu_bypass     = cpu_valid && !cacheable;
    // invalidate yields to a cacheable access offered in the same cycle
    assign inv_ready      = cpu_ready && !(cpu_valid && cacheable);
    assign link_req_valid = (state_q == `DMC_ST_FILL_REQ) || (state_q == `DMC_ST_WRITE_REQ);
    assign link_req_write = (state_q == `DMC_ST_WRITE_REQ);

    // storage arrays carry no reset; the valid bits guard them
    // a write hit and a fill never meet: a fill only runs while nothing is taken
    always @(posedge clk_sys) begin
        if (ce) begin
            if (take && cpu_write && hit) begin
                data_mem[widx] <= merged;
            end
            if (state_q == `DMC_ST_FILL_DATA && link_rsp_valid) begin
                data_mem[{fl_idx, cnt_q}] <= link_rsp_data;
                if (fl_last) begin
                    tag_mem[fl_idx] <= fl_tag;
                end
            end
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            state_q          <= `DMC_ST_IDLE;
            lvalid_q         <= {NL{1'b0}};
            wvalid_q         <= {NW{1'b0}};
            op_addr_q        <= 32'h0000_0000;
            cnt_q            <= {LINE_LOG2{1'b0}};
            cpu_ack_q        <= 1'b0;
            cpu_rdata_q      <= 32'h0000_0000;
            link_req_addr_q  <= 32'h0000_0000;
            link_req_be_q    <= 4'h0;
            link_req_wdata_q <= 32'h0000_0000;
        end else if (ce) begin
            cpu_ack_q <= 1'b0;
            // disabling leaves all arrays untouched
            // invalidate clears only the line-valid bit; the word-valid bits stay set
            // and are harmless because a hit needs both
            if ((ALLOW_INV != 0) && inv_valid && inv_ready) begin
                lvalid_q[inv_idx] <= 1'b0;
            end
            case (state_q)
                `DMC_ST_IDLE: begin
                    if (take) begin
                        op_addr_q <= cpu_addr;
                        if (cpu_write) begin
                            // write-through, no allocation on a miss
                            link_req_addr_q  <= cpu_addr;
                            link_req_be_q    <= cpu_be;
                            link_req_wdata_q <= cpu_wdata;
                            state_q          <= `DMC_ST_WRITE_REQ;
                        end else if (hit) begin
                            cpu_rdata_q <= data_mem[widx];
                            cpu_ack_q   <= 1'b1;
                        end else begin
                            // the line read starts at word 0; the wanted word is picked en route
                            link_req_addr_q  <= {cpu_addr[31:2+LINE_LOG2],
                                                 {(2+LINE_LOG2){1'b0}}};
                            link_req_be_q    <= 4'hF;
                            link_req_wdata_q <= 32'h0000_0000;
                            state_q          <= `DMC_ST_FILL_REQ;
                        end
                    end
                end
                `DMC_ST_FILL_REQ: begin
                    if (link_req_ready) begin
                        cnt_q   <= {LINE_LOG2{1'b0}};
                        state_q <= `DMC_ST_FILL_DATA;
                    end
                end
                `DMC_ST_FILL_DATA: begin
                    // the controller returns the whole line, word 0 first
                    // a word arriving after the last one falls into idle and is ignored
                    if (link_rsp_valid) begin
                        cnt_q <= cnt_q + {{(LINE_LOG2-1){1'b0}}, 1'b1};
                        if (cnt_q == fl_word) begin
                            cpu_rdata_q <= link_rsp_data;
                        end
                        if (fl_last) begin
                            wvalid_q[{fl_idx, {LINE_LOG2{1'b0}}} +: LW] <= {LW{1'b1}};
                            lvalid_q[fl_idx] <= 1'b1;
                            cpu_ack_q        <= 1'b1;
                            state_q          <= `DMC_ST_IDLE;
                        end
                    end
                end
                `DMC_ST_WRITE_REQ: begin
                    // the store is acknowledged once the link takes it;
                    // memory may land it later, so software must fence before
                    // reading the same word back over another bus
                    if (link_req_ready) begin
                        cpu_ack_q <= 1'b1;
                        state_q   <= `DMC_ST_IDLE;
                    end
                end
                default: begin
                    state_q <= `DMC_ST_IDLE;
                end
            endcase
        end
    end
endmodule

module dmc_cache (
    // clock, reset, freeze
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        ce,
    // machine status register enable bits
    input  wire        instr_cache_enable_bit,
    input  wire        data_cache_enable_bit,
    // instruction fetch port
    input  wire        ic_fetch_valid,
    input  wire [31:0] ic_fetch_addr,
    output wire        ic_fetch_ready,
    output wire        ic_fetch_bypass,
    output wire        ic_fetch_ack,
    output wire [31:0] ic_fetch_data,
    // instruction line invalidate
    input  wire        icache_line_invalidate_op,
    input  wire [31:0] ic_inv_addr,
    output wire        ic_inv_ready,
    // instruction line-fill link
    output wire        ilink_req_valid,
    output wire [31:0] ilink_req_addr,
    input  wire        ilink_req_ready,
    input  wire        ilink_rsp_valid,
    input  wire [31:0] ilink_rsp_data,
    // data access port
    input  wire        dc_valid,
    input  wire [31:0] dc_addr,
    input  wire        dc_write,
    input  wire [3:0]  dc_be,
    input  wire [31:0] dc_wdata,
    output wire        dc_ready,
    output wire        dc_bypass,
    output wire        dc_ack,
    output wire [31:0] dc_rdata,
    // data line invalidate
    input  wire        dcache_line_invalidate_op,
    input  wire [31:0] dc_inv_addr,
    output wire        dc_inv_ready,
    // data line-fill link
    output wire        dlink_req_valid,
    output wire        dlink_req_write,
    output wire [31:0] dlink_req_addr,
    output wire [3:0]  dlink_req_be,
    output wire [31:0] dlink_req_wdata,
    input  wire        dlink_req_ready,
    input  wire        dlink_rsp_valid,
    input  wire [31:0] dlink_rsp_data
);
    // software must not place local-bus addresses in the data window
    // each cache has its own window, link and invalidate port
    // the instruction side never writes: its write lanes are tied off
    dmc_cache_core #(
        .RANGE_LOW  (`DMC_IC_RANGE_LOW),
        .RANGE_HIGH (`DMC_IC_RANGE_HIGH),
        .RANGE_BITS (`DMC_IC_RANGE_BITS),
        .CACHE_BITS (`DMC_IC_CACHE_BITS),
        .LINE_LOG2  (`DMC_IC_LINE_LOG2),
        .ALLOW_INV  (`DMC_IC_ALLOW_INV)
    ) u_icache (
        // fetch port and line reads only
        .clk_sys          (clk_sys),
        .rst              (rst),
        .ce               (ce),
        .cache_enable     (instr_cache_enable_bit),
        .cpu_valid        (ic_fetch_valid),
        .cpu_addr         (ic_fetch_addr),
        .cpu_write        (1'b0),
        .cpu_be           (4'hF),
        .cpu_wdata        (32'h0000_0000),
        .cpu_ready        (ic_fetch_ready),
        .cpu_bypass       (ic_fetch_bypass),
        .cpu_ack_q        (ic_fetch_ack),
        .cpu_rdata_q      (ic_fetch_data),
        .inv_valid        (icache_line_invalidate_op),
        .inv_addr         (ic_inv_addr),
        .inv_ready        (ic_inv_ready),
        .link_req_valid   (ilink_req_valid),
        .link_req_write   (),
        .link_req_addr_q  (ilink_req_addr),
        .link_req_be_q    (),
        .link_req_wdata_q (),
        .link_req_ready   (ilink_req_ready),
        .link_rsp_valid   (ilink_rsp_valid),
        .link_rsp_data    (ilink_rsp_data)
    );

    dmc_cache_core #(
        .RANGE_LOW  (`DMC_DC_RANGE_LOW),
        .RANGE_HIGH (`DMC_DC_RANGE_HIGH),
        .RANGE_BITS (`DMC_DC_RANGE_BITS),
        .CACHE_BITS (`DMC_DC_CACHE_BITS),
        .LINE_LOG2  (`DMC_DC_LINE_LOG2),
        .ALLOW_INV  (`DMC_DC_ALLOW_INV)
    ) u_dcache (
        // store write-through and line reads share one link
        .clk_sys          (clk_sys),
        .rst              (rst),
        .ce               (ce),
        .cache_enable     (data_cache_enable_bit),
        .cpu_valid        (dc_valid),
        .cpu_addr         (dc_addr),
        .cpu_write        (dc_write),
        .cpu_be           (dc_be),
        .cpu_wdata        (dc_wdata),
        .cpu_ready        (dc_ready),
        .cpu_bypass       (dc_bypass),
        .cpu_ack_q        (dc_ack),
        .cpu_rdata_q      (dc_rdata),
        .inv_valid        (dcache_line_invalidate_op),
        .inv_addr         (dc_inv_addr),
        .inv_ready        (dc_inv_ready),
        .link_req_valid   (dlink_req_valid),
        .link_req_write   (dlink_req_write),
        .link_req_addr_q  (dlink_req_addr),
        .link_req_be_q    (dlink_req_be),
        .link_req_wdata_q (dlink_req_wdata),
        .link_req_ready   (dlink_req_ready),
        .link_rsp_valid   (dlink_rsp_valid),
        .link_rsp_data    (dlink_rsp_data)
    );
endmodule

// ### rtl/dmc_cache_defines.vh
`ifndef DMC_CACHE_DEFINES_VH
`define DMC_CACHE_DEFINES_VH

// instruction cache: 64 kB cacheable window, 4 kB cache, 8-word lines
`define DMC_IC_RANGE_LOW    32'h0030_0000
`define DMC_IC_RANGE_HIGH   32'h0030_FFFF
`define DMC_IC_RANGE_BITS   16
`define DMC_IC_CACHE_BITS   12
`define DMC_IC_LINE_LOG2    3
`define DMC_IC_ALLOW_INV    1

// data cache: 16 kB cacheable window, 2 kB cache, 4-word lines
`define DMC_DC_RANGE_LOW    32'h0040_0000
`define DMC_DC_RANGE_HIGH   32'h0040_3FFF
`define DMC_DC_RANGE_BITS   14
`define DMC_DC_CACHE_BITS   11
`define DMC_DC_LINE_LOG2    2
`define DMC_DC_ALLOW_INV    1

// controller states
`define DMC_ST_IDLE         2'h0
`define DMC_ST_FILL_REQ     2'h1
`define DMC_ST_FILL_DATA    2'h2
`define DMC_ST_WRITE_REQ    2'h3

`endif

// ### verif/dmc_cache_props.sv
`timescale 1ns/1ps
`include "dmc_cache_defines.vh"
module dmc_cache_props (
    // clock, reset, freeze, enables
    input wire        clk_sys,
    input wire        rst,
    input wire        ce,
    input wire        instr_cache_enable_bit,
    input wire        data_cache_enable_bit,
    // instruction side
    input wire        ic_fetch_valid,
    input wire [31:0] ic_fetch_addr,
    input wire        ic_fetch_ready,
    input wire        ic_fetch_bypass,
    input wire        ic_fetch_ack,
    input wire        ilink_req_valid,
    input wire [31:0] ilink_req_addr,
    input wire        ilink_req_ready,
    // data side
    input wire        dc_valid,
    input wire [31:0] dc_addr,
    input wire        dc_write,
    input wire        dc_ready,
    input wire        dc_bypass,
    input wire        dc_ack,
    input wire        dlink_req_valid,
    input wire        dlink_req_write,
    input wire [31:0] dlink_req_addr,
    input wire        dlink_req_ready
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire ic_in = ic_fetch_addr >= `DMC_IC_RANGE_LOW && ic_fetch_addr <= `DMC_IC_RANGE_HIGH;
    wire dc_in = dc_addr >= `DMC_DC_RANGE_LOW && dc_addr <= `DMC_DC_RANGE_HIGH;
    wire ic_take = ce && ic_fetch_valid && ic_fetch_ready && instr_cache_enable_bit && ic_in;
    wire dc_take = ce && dc_valid && dc_ready && data_cache_enable_bit && dc_in;

    ic_bypass_a: assert property (
        ic_fetch_bypass == (ic_fetch_valid && !(instr_cache_enable_bit && ic_in)))
        else $error("icache bypass does not follow window and enable");
    dc_bypass_a: assert property (
        dc_bypass == (dc_valid && !(data_cache_enable_bit && dc_in)))
        else $error("dcache bypass does not follow window and enable");
    ic_take_answer_a: assert property (ic_take |=> ic_fetch_ack || ilink_req_valid)
        else $error("icache take gave neither hit nor fill request");
    dc_read_answer_a: assert property (
        dc_take && !dc_write |=> dc_ack || (dlink_req_valid && !dlink_req_write))
        else $error("dcache load gave neither hit nor line request");
    dc_write_thru_a: assert property (
        dc_take && dc_write |=> dlink_req_valid && dlink_req_write)
        else $error("store not written through");
    ic_req_hold_a: assert property (
        ilink_req_valid && !ilink_req_ready |=> ilink_req_valid && $stable(ilink_req_addr))
        else $error("icache line request dropped or changed");
    ic_line_align_a: assert property (
        ilink_req_valid |-> ilink_req_addr[4:0] == 5'h00 && ilink_req_addr[31:16] == 16'h0030)
        else $error("icache line request not an 8-word line in window");
    dc_line_align_a: assert property (
        dlink_req_valid && !dlink_req_write |-> dlink_req_addr[3:0] == 4'h0)
        else $error("dcache line request not 4-word aligned");
    dc_wr_ack_a: assert property (
        ce && dlink_req_valid && dlink_req_write && dlink_req_ready |=> dc_ack && dc_ready)
        else $error("store not acknowledged after link accept");
    reset_idle_a: assert property (disable iff (1'b0)
        rst && ce |=> ic_fetch_ready && dc_ready && !ilink_req_valid && !dlink_req_valid)
        else $error("caches not idle after reset");

    ic_miss_c: cover property (ilink_req_valid && ilink_req_ready);
    dc_write_c: cover property (dlink_req_valid && dlink_req_write && dlink_req_ready);
    dc_bypass_c: cover property (dc_bypass);
endmodule

bind dmc_cache dmc_cache_props i_props (.*);

// ### verif/dmc_cache_tb.sv
`timescale 1ns/1ps
module dmc_cache_tb;
    logic        clk_sys = 1'b0, rst = 1'b1, ce = 1'b1, slow = 1'b0, byp;
    logic        instr_cache_enable_bit = 1'b0, data_cache_enable_bit = 1'b0;
    logic        ic_fetch_valid = 1'b0, icache_line_invalidate_op = 1'b0;
    logic        dc_valid = 1'b0, dc_write = 1'b0, dcache_line_invalidate_op = 1'b0;
    logic [31:0] ic_fetch_addr = 32'h0000_0000, ic_inv_addr = 32'h0000_0000;
    logic [31:0] dc_addr = 32'h0000_0000, dc_wdata = 32'h0000_0000;
    logic [31:0] dc_inv_addr = 32'h0000_0000, rd, mirror, wd, m;
    logic [3:0]  dc_be = 4'h0, dlink_req_be;
    logic [31:0] ic_fetch_data, dc_rdata, ilink_req_addr, ilink_rsp_data, ic_rds, dc_rds;
    logic [31:0] dlink_req_addr, dlink_req_wdata, dlink_rsp_data;
    logic        ic_fetch_ready, ic_fetch_bypass, ic_fetch_ack, ic_inv_ready;
    logic        ilink_req_valid, ilink_req_ready, ilink_rsp_valid, dlink_req_ready;
    logic        dc_ready, dc_bypass, dc_ack, dc_inv_ready, dlink_req_valid;
    logic        dlink_req_write, dlink_rsp_valid;
    logic [67:0] dc_last_wr;
    logic [3:0]  bes [3] = '{4'hF, 4'hC, 4'h2};
    int          fail_count = 0, checked = 0, cyc = 0;

    always #50 clk_sys = ~clk_sys;

    dmc_cache i_dut (.*);
    dmc_mem_model #(.N(8)) i_imem (.clk_sys(clk_sys), .rst(rst), .slow(slow),
        .req_valid(ilink_req_valid), .req_write(1'b0), .req_addr(ilink_req_addr),
        .req_wr({68{1'b0}}), .req_ready(ilink_req_ready), .rsp_valid(ilink_rsp_valid),
        .rsp_data(ilink_rsp_data), .last_wr(), .rd_cnt(ic_rds));
    dmc_mem_model #(.N(4)) i_dmem (.clk_sys(clk_sys), .rst(rst), .slow(slow),
        .req_valid(dlink_req_valid), .req_write(dlink_req_write), .req_addr(dlink_req_addr),
        .req_wr({dlink_req_addr, dlink_req_be, dlink_req_wdata}),
        .req_ready(dlink_req_ready), .rsp_valid(dlink_rsp_valid),
        .rsp_data(dlink_rsp_data), .last_wr(dc_last_wr), .rd_cnt(dc_rds));

    task automatic test_done();
        $display("compares %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            test_done();
        end
    end

    task automatic chk(input logic [67:0] got, input logic [67:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] word(input logic [31:0] a);
        return {a[31:2], 2'b00} ^ 32'hC0DE_0000;
    endfunction

    // valid drops at the edge that takes the request, else it would be taken twice
    task automatic acc(input bit d, input bit w, input logic [31:0] a,
                       input logic [3:0] be, input logic [31:0] wdat);
        int n;
        n = 0;
        ic_fetch_valid <= !d;
        dc_valid       <= d;
        ic_fetch_addr  <= a;
        dc_addr        <= a;
        dc_write       <= w;
        dc_be          <= be;
        dc_wdata       <= wdat;
        do begin
            @(posedge clk_sys);
            n++;
            byp = d ? dc_bypass : ic_fetch_bypass;
        end while (!byp && !(d ? dc_ready : ic_fetch_ready) && n < 40);
        ic_fetch_valid <= 1'b0;
        dc_valid       <= 1'b0;
        while (!byp && !(d ? dc_ack : ic_fetch_ack) && n < 80) begin
            @(posedge clk_sys);
            n++;
        end
        rd = d ? dc_rdata : ic_fetch_data;
        if (n >= 80) fail_count++;
    endtask

    task automatic rd_chk(input bit d, input logic [31:0] a, input logic [31:0] exp,
                          input logic [31:0] fills);
        acc(d, 1'b0, a, 4'hF, 32'h0000_0000);
        chk(68'(byp), 68'(0));
        chk(68'(rd), 68'(exp));
        chk(68'(d ? dc_rds : ic_rds), 68'(fills));
    endtask

    task automatic byp_chk(input bit d, input logic [31:0] a);
        acc(d, 1'b0, a, 4'hF, 32'h0000_0000);
        chk(68'(byp), 68'(1));
    endtask

    task automatic inv(input bit d, input logic [31:0] a);
        icache_line_invalidate_op <= !d;
        dcache_line_invalidate_op <= d;
        ic_inv_addr               <= a;
        dc_inv_addr               <= a;
        do @(posedge clk_sys); while (!(d ? dc_inv_ready : ic_inv_ready));
        icache_line_invalidate_op <= 1'b0;
        dcache_line_invalidate_op <= 1'b0;
    endtask

    task automatic toggle(input bit d, input bit last);
        if (d) data_cache_enable_bit <= 1'b0;
        else instr_cache_enable_bit <= 1'b0;
        @(posedge clk_sys);
        if (d) data_cache_enable_bit <= last;
        else instr_cache_enable_bit <= last;
    endtask

    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        byp_chk(0, 32'h0030_0010);
        instr_cache_enable_bit <= 1'b1;
        byp_chk(0, 32'h0031_0000);
        byp_chk(0, 32'h002F_FFFC);
        rd_chk(0, 32'h0030_FFFC, word(32'h0030_FFFC), 1);
        rd_chk(0, 32'h0030_FFE0, word(32'h0030_FFE0), 1);
        rd_chk(0, 32'h0030_EFE4, word(32'h0030_EFE4), 2);
        rd_chk(0, 32'h0030_FFFC, word(32'h0030_FFFC), 3);
        toggle(0, 1'b1);
        rd_chk(0, 32'h0030_FFF0, word(32'h0030_FFF0), 3);
        toggle(0, 1'b0);
        inv(0, 32'h0030_FFE0);
        instr_cache_enable_bit <= 1'b1;
        rd_chk(0, 32'h0030_FFF0, word(32'h0030_FFF0), 4);
        $display("test icache done");
        slow <= 1'b1;
        byp_chk(1, 32'h0040_3FF8);
        data_cache_enable_bit <= 1'b1;
        byp_chk(1, 32'h0040_4000);
        rd_chk(1, 32'h0040_3FF8, word(32'h0040_3FF8), 1);
        rd_chk(1, 32'h0040_3FF0, word(32'h0040_3FF0), 1);
        mirror = word(32'h0040_3FF4);
        for (int i = 0; i < 3; i++) begin
            wd = 32'h1111_1111 * (i + 1);
            m  = {{8{bes[i][3]}}, {8{bes[i][2]}}, {8{bes[i][1]}}, {8{bes[i][0]}}};
            mirror = (mirror & ~m) | (wd & m);
            acc(1, 1'b1, 32'h0040_3FF4, bes[i], wd);
            chk(dc_last_wr, {32'h0040_3FF4, bes[i], wd});
        end
        rd_chk(1, 32'h0040_3FF4, mirror, 1);
        acc(1, 1'b1, 32'h0040_0100, 4'h3, 32'h0000_BEEF);
        chk(dc_last_wr, {32'h0040_0100, 4'h3, 32'h0000_BEEF});
        rd_chk(1, 32'h0040_0100, word(32'h0040_0100), 2);
        toggle(1, 1'b1);
        rd_chk(1, 32'h0040_3FF4, mirror, 2);
        inv(1, 32'h0040_3FF0);
        rd_chk(1, 32'h0040_3FF4, word(32'h0040_3FF4), 3);
        $display("test dcache done");
        rst <= 1'b1;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        rd_chk(1, 32'h0040_3FF4, word(32'h0040_3FF4), 1);
        rd_chk(0, 32'h0030_FFF0, word(32'h0030_FFF0), 1);
        $display("test reset done");
        test_done();
    end
endmodule

// ### verif/dmc_mem_model.sv
`timescale 1ns/1ps
// line-fill controller: fill words are a fixed function of address; stores are
// only recorded, so a later fill of a stored word still returns the old value
module dmc_mem_model #(
    parameter N = 4
) (
    // clock, reset, pacing
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        slow,
    // request side
    input  wire        req_valid,
    input  wire        req_write,
    input  wire [31:0] req_addr,
    input  wire [67:0] req_wr,
    output reg         req_ready,
    // fill response
    output reg         rsp_valid,
    output reg  [31:0] rsp_data,
    // observation
    output reg  [67:0] last_wr,
    output reg  [31:0] rd_cnt
);
    reg        busy_q;
    reg        tick_q;
    reg [3:0]  k_q;
    reg [31:0] base_q;

    always @(posedge clk_sys) begin
        tick_q    <= ~tick_q;
        req_ready <= 1'b0;
        rsp_valid <= 1'b0;
        rsp_data  <= ~rsp_data; // idle data inverts every cycle, so the first idle cycle never repeats the last word
        if (rst) begin
            busy_q   <= 1'b0;
            tick_q   <= 1'b0;
            rd_cnt   <= 32'h0000_0000;
            rsp_data <= 32'h0000_0000;
            last_wr  <= {68{1'b0}};
        end else if (busy_q) begin
            // slow mode leaves a gap between words; the first word is not delayed
            if (!slow || tick_q) begin
                rsp_valid <= 1'b1;
                rsp_data  <= (base_q + {k_q, 2'b00}) ^ 32'hC0DE_0000;
                k_q       <= k_q + 4'h1;
                busy_q    <= (k_q != N - 1);
            end
        end else if (req_valid && req_ready) begin
            if (req_write) begin
                last_wr <= req_wr;
            end else begin
                busy_q <= 1'b1;
                k_q    <= 4'h0;
                base_q <= req_addr;
                rd_cnt <= rd_cnt + 32'h0000_0001;
            end
        end else if (req_valid && (!slow || tick_q)) begin
            req_ready <= 1'b1;
        end
    end
endmodule
